/* rtl/cgr_pkg.sv */
package cgr_pkg;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] ADDR_RESERVED_A = 8'h04;
   localparam logic [7:0] ADDR_REV_VENDOR = 8'h05;
   localparam logic [7:0] ADDR_DEVICE = 8'h06;
   localparam logic [7:0] ADDR_COUNT = 8'h07;
   localparam logic [7:0] ADDR_RESERVED_B = 8'h08;
   localparam logic [7:0] ADDR_RESERVED_C = 8'h09;
   localparam logic [7:0] ADDR_DIVIDER = 8'h0a;
   localparam logic [7:0] ADDR_STOP = 8'h0b;
   localparam logic [7:0] ADDR_IMP_LOW = 8'h0c;
   localparam logic [7:0] ADDR_IMP_HIGH = 8'h0d;
   localparam logic [7:0] ADDR_RESISTOR = 8'h0e;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int COUNT_WIDTH = 5;
   localparam int DIVIDER_BIT = 7;
   localparam int KEEP_BIT = 6;
   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [4:0] COUNT_RESET = 5'h08;
   localparam logic KEEP_RESET = 1'b1;
   localparam logic [1:0] STOP_RESET = 2'h0;
   localparam logic [7:0] RESISTOR_RESET = 8'h55;
   localparam logic [15:0] IMP_RESET_100 = 16'haaaa;
   localparam logic [15:0] IMP_RESET_85 = 16'h5555;
   // ************************************************************
   // Stop level encodings
   // ************************************************************
   localparam logic [1:0] STOP_LOW = 2'h0;
   localparam logic [1:0] STOP_HIZ = 2'h1;
   localparam logic [1:0] STOP_HIGH_LOW = 2'h2;
   localparam logic [1:0] STOP_LOW_HIGH = 2'h3;
   typedef enum logic [1:0] {BLK_IDLE, BLK_COUNT, BLK_DATA} cgr_blk_state_type;
endpackage : cgr_pkg

/* rtl/cgr_stop_if.sv */
`timescale 1ns/1ps
interface cgr_stop_if;
   logic [1:0] stop_level_select;
   logic [7:0] pair_enable;
   logic ref_enable;
   logic [7:0] true_level;
   logic [7:0] comp_level;
   logic [7:0] pair_drive_en;
   logic ref_level;
   logic ref_drive_en;
   modport cfg (output stop_level_select, pair_enable, ref_enable,
      input true_level, comp_level, pair_drive_en, ref_level, ref_drive_en);
   modport dec (input stop_level_select, pair_enable, ref_enable,
      output true_level, comp_level, pair_drive_en, ref_level, ref_drive_en);
endinterface : cgr_stop_if

/* rtl/cgr_stop_decode.sv */
`timescale 1ns/1ps
module cgr_stop_decode
   import cgr_pkg::*;
(
   cgr_stop_if.dec stop
);
   // ************************************************************
   // Disabled output levels
   // ************************************************************
   always_comb
   begin
      for (int k = 0; k < 8; k++)
      begin
         // Running pair shows high/low; the analog clock path overrides it
         stop.true_level[k] = 1'b1;
         stop.comp_level[k] = 1'b0;
         stop.pair_drive_en[k] = 1'b1;
         if (!stop.pair_enable[k])
         begin
            case (stop.stop_level_select)
               STOP_HIZ:
               begin
                  stop.pair_drive_en[k] = 1'b0;
               end
               STOP_HIGH_LOW:
               begin
                  stop.true_level[k] = 1'b1;
               end
               STOP_LOW_HIGH:
               begin
                  stop.true_level[k] = 1'b0;
                  stop.comp_level[k] = 1'b1;
               end
               default:
               begin
                  stop.true_level[k] = 1'b0;
               end
            endcase
         end
      end
      stop.ref_level = 1'b1;
      stop.ref_drive_en = 1'b1;
      if (!stop.ref_enable)
      begin
         case (stop.stop_level_select)
            STOP_HIZ: stop.ref_drive_en = 1'b0;
            STOP_LOW_HIGH: stop.ref_level = 1'b1;
            default: stop.ref_level = 1'b0;
         endcase
      end
   end
endmodule : cgr_stop_decode

/* rtl/cgr_config_regs.sv */
`timescale 1ns/1ps
module cgr_config_regs
   import cgr_pkg::*;
#(
   parameter logic [3:0] REVISION = 4'h3, // Arbitrary value
   parameter logic [3:0] VENDOR = 4'h5, // Arbitrary value
   parameter logic [1:0] DEVICE_TYPE = 2'h3, // Arbitrary value
   parameter logic [5:0] DEVICE_ID = 6'h15, // Arbitrary value
   parameter logic DIVIDER_RESET = 1'b0,
   parameter logic [15:0] IMP_RESET = cgr_pkg::IMP_RESET_100
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic [7:0] reg_rd_addr,
   output logic [7:0] reg_rd_data,
   input wire logic blk_start,
   input wire logic [7:0] blk_index,
   input wire logic blk_next,
   input wire logic blk_stop,
   output logic blk_valid,
   output logic [7:0] blk_data,
   input wire logic [7:0] output_enable_bits,
   input wire logic [7:0] oe_pin_n,
   input wire logic ref_enable,
   input wire logic power_down_n,
   output logic [7:0] differential_clock_output_true,
   output logic [7:0] differential_clock_output_comp,
   output logic [7:0] differential_clock_output_oe,
   output logic ref_level,
   output logic ref_oe,
   output logic divider_prog_enable,
   output logic [15:0] output_impedance_select,
   output logic [7:0] enable_pin_resistor_select,
   output logic [4:0] readback_count
);
   import cgr_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [7:0] pin_sync1;
      logic [7:0] pin_sync2;
      logic pd_sync1;
      logic pd_sync2;
      logic [4:0] readback_count;
      logic divider_enable;
      logic config_keep;
      logic [1:0] stop_level;
      logic [15:0] impedance;
      logic [7:0] resistor;
      logic [7:0] rd_data;
      cgr_blk_state_type blk_state;
      logic blk_busy;
      logic [7:0] blk_ptr;
      logic [4:0] blk_left;
      logic [7:0] blk_data;
      logic [7:0] pair_true;
      logic [7:0] pair_comp;
      logic [7:0] pair_oe;
      logic ref_level;
      logic ref_oe;
   } cgr_state_type;

   cgr_state_type state;
   cgr_state_type next_state;
   logic [7:0] pair_on;
   cgr_stop_if stop_bus ();

   function automatic cgr_state_type with_defaults(input cgr_state_type s);
      cgr_state_type r;
      r = s;
      r.readback_count = COUNT_RESET;
      r.divider_enable = DIVIDER_RESET;
      r.config_keep = KEEP_RESET;
      r.stop_level = STOP_RESET;
      r.impedance = IMP_RESET;
      r.resistor = RESISTOR_RESET;
      return r;
   endfunction : with_defaults

   function automatic logic [7:0] read_byte(input cgr_state_type s, input logic [7:0] addr);
      logic [7:0] r;
      r = 8'h00; // Reserved and unmapped bytes read zero
      case (addr)
         ADDR_REV_VENDOR: r = {REVISION, VENDOR};
         ADDR_DEVICE: r = {DEVICE_TYPE, DEVICE_ID};
         ADDR_COUNT: r = {3'h0, s.readback_count};
         ADDR_DIVIDER: r = {s.divider_enable, s.config_keep, 6'h00};
         ADDR_STOP: r = {6'h00, s.stop_level};
         ADDR_IMP_LOW: r = s.impedance[7:0];
         ADDR_IMP_HIGH: r = s.impedance[15:8];
         ADDR_RESISTOR: r = s.resistor;
         default: r = 8'h00;
      endcase
      return r;
   endfunction : read_byte

   // ************************************************************
   // Stop level decoder
   // ************************************************************
   // Pin is active low; a cleared enable bit overrides it
   assign pair_on = output_enable_bits & ~state.pin_sync2;
   assign stop_bus.stop_level_select = state.stop_level;
   assign stop_bus.pair_enable = pair_on;
   assign stop_bus.ref_enable = ref_enable;

   cgr_stop_decode u_stop_decode (
      .stop (stop_bus.dec)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      next_state = state;
      next_state.pin_sync1 = oe_pin_n;
      next_state.pin_sync2 = state.pin_sync1;
      next_state.pd_sync1 = power_down_n;
      next_state.pd_sync2 = state.pd_sync1;
      if (reg_wr_en)
      begin
         // Identity and reserved bytes fall to default and are dropped
         case (reg_wr_addr)
            ADDR_COUNT: next_state.readback_count = reg_wr_data[COUNT_WIDTH-1:0];
            ADDR_DIVIDER:
            begin
               next_state.divider_enable = reg_wr_data[DIVIDER_BIT];
               next_state.config_keep = reg_wr_data[KEEP_BIT];
            end
            ADDR_STOP: next_state.stop_level = reg_wr_data[1:0];
            ADDR_IMP_LOW: next_state.impedance[7:0] = reg_wr_data;
            ADDR_IMP_HIGH: next_state.impedance[15:8] = reg_wr_data;
            ADDR_RESISTOR: next_state.resistor = reg_wr_data;
            default: next_state.resistor = state.resistor;
         endcase
      end
      // Clearing wins over a write landing in the same cycle
      if (!state.pd_sync2 && !state.config_keep)
      begin
         next_state = with_defaults(next_state);
      end
      next_state.rd_data = read_byte(state, reg_rd_addr);
      case (state.blk_state)
         BLK_IDLE:
         begin
            if (blk_start)
            begin
               next_state.blk_state = BLK_COUNT;
               next_state.blk_data = {3'h0, state.readback_count};
               next_state.blk_left = state.readback_count;
               next_state.blk_ptr = blk_index;
            end
         end
         BLK_COUNT, BLK_DATA:
         begin
            if (blk_stop)
            begin
               next_state.blk_state = BLK_IDLE;
            end
            else if (blk_next)
            begin
               if (state.blk_left == 5'h00)
               begin
                  next_state.blk_state = BLK_IDLE;
               end
               else
               begin
                  next_state.blk_state = BLK_DATA;
                  next_state.blk_data = read_byte(state, state.blk_ptr);
                  next_state.blk_ptr = state.blk_ptr + 8'h01;
                  next_state.blk_left = state.blk_left - 5'h01;
               end
            end
         end
         default: next_state.blk_state = BLK_IDLE;
      endcase
      // Own flop so the valid output carries no decode glitch
      next_state.blk_busy = (next_state.blk_state != BLK_IDLE);
      next_state.pair_true = stop_bus.true_level;
      next_state.pair_comp = stop_bus.comp_level;
      next_state.pair_oe = stop_bus.pair_drive_en;
      next_state.ref_level = stop_bus.ref_level;
      next_state.ref_oe = stop_bus.ref_drive_en;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         state <= with_defaults('0);
      end
      else
      begin
         state <= next_state;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign reg_rd_data = state.rd_data;
   assign blk_valid = state.blk_busy;
   assign blk_data = state.blk_data;
   assign differential_clock_output_true = state.pair_true;
   assign differential_clock_output_comp = state.pair_comp;
   assign differential_clock_output_oe = state.pair_oe;
   assign ref_level = state.ref_level;
   assign ref_oe = state.ref_oe;
   assign divider_prog_enable = state.divider_enable;
   assign output_impedance_select = state.impedance;
   assign enable_pin_resistor_select = state.resistor;
   assign readback_count = state.readback_count;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   a_reset_values: assert property ($past(sys_rst) |-> state.readback_count == 5'h08
      && state.resistor == 8'h55 && state.impedance == IMP_RESET
      && state.divider_enable == DIVIDER_RESET && state.config_keep)
      else $error("Configuration reset values wrong");
   a_ident_rev: assert property (reg_rd_addr == 8'h05 |=> reg_rd_data == {REVISION, VENDOR})
      else $error("Revision byte wrong");
   a_ident_device: assert property (reg_rd_addr == 8'h06 |=> reg_rd_data == {DEVICE_TYPE, DEVICE_ID})
      else $error("Device byte wrong");
   a_reserved_zero: assert property (reg_rd_addr == 8'h09 ##1 reg_rd_addr == 8'h04 |=>
      reg_rd_data == 8'h00 && $past(reg_rd_data) == 8'h00)
      else $error("Reserved byte not zero");
   a_count_write: assert property (reg_wr_en && reg_wr_addr == 8'h07 && state.config_keep |=>
      readback_count == $past(reg_wr_data[4:0]))
      else $error("Byte count write lost");
   a_pair_stop: assert property (!pair_on[0] && state.stop_level == 2'h3 |=>
      !differential_clock_output_true[0] && differential_clock_output_comp[0]
      && differential_clock_output_oe[0])
      else $error("Disabled pair not low/high");
   a_pair_hiz: assert property (!pair_on[7] && state.stop_level == 2'h1 |=>
      !differential_clock_output_oe[7])
      else $error("Disabled pair still driven");
   a_ref_stop: assert property (!ref_enable && state.stop_level == 2'h2 |=>
      !ref_level && ref_oe)
      else $error("Reference stop level wrong");
   a_keep_clear: assert property (!state.pd_sync2 && !state.config_keep |=>
      state.readback_count == 5'h08 && state.stop_level == 2'h0 && state.config_keep)
      else $error("Powerdown clear missed");
   a_block_count: assert property (blk_start && !blk_valid |=> blk_valid
      && blk_data == {3'h0, $past(state.readback_count)})
      else $error("Block read did not open with count");
endmodule : cgr_config_regs

/* testbench/cgr_host_model.sv */
`timescale 1ns/1ps
// ************************************************************
// Host side of the byte engine: register and block transfers
// ************************************************************
module cgr_host_model
(
   input wire logic clock,
   output logic reg_wr_en,
   output logic [7:0] reg_wr_addr,
   output logic [7:0] reg_wr_data,
   output logic [7:0] reg_rd_addr,
   input wire logic [7:0] reg_rd_data,
   output logic blk_start,
   output logic [7:0] blk_index,
   output logic blk_next,
   output logic blk_stop
);
   initial
   begin
      {reg_wr_en, reg_wr_addr, reg_wr_data, reg_rd_addr} = '0;
      {blk_start, blk_index, blk_next, blk_stop} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_wr_en = 1'b1;
      reg_wr_addr = a;
      reg_wr_data = d;
      @(negedge clock);
      reg_wr_en = 1'b0;
      // Stale bus must not look valid
      reg_wr_data = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      reg_rd_addr = a;
      @(negedge clock);
      d = reg_rd_data;
   endtask : rd
   task automatic blk_open(input logic [7:0] idx);
      @(negedge clock);
      blk_start = 1'b1;
      blk_index = idx;
      @(negedge clock);
      blk_start = 1'b0;
      blk_index = ~idx;
   endtask : blk_open
   task automatic blk_ack(input logic nack);
      @(negedge clock);
      blk_next = ~nack;
      blk_stop = nack;
      @(negedge clock);
      blk_next = 1'b0;
      blk_stop = 1'b0;
   endtask : blk_ack
endmodule : cgr_host_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import cgr_pkg::*;
   // Arbitrary identity values
   localparam logic [3:0] REV = 4'h6;
   localparam logic [3:0] VEN = 4'h9;
   localparam logic [1:0] DTYPE = 2'h3;
   localparam logic [5:0] DID = 6'h2a;
   localparam logic DIV_RST = 1'b1;
   logic clock, sys_rst, reg_wr_en, blk_start, blk_next, blk_stop, blk_valid;
   logic [7:0] reg_wr_addr, reg_wr_data, reg_rd_addr, reg_rd_data, blk_index, blk_data;
   logic [7:0] output_enable_bits, oe_pin_n, pair_t, pair_c, pair_oe, res_sel;
   logic ref_enable, power_down_n, ref_level, ref_oe, divider_prog_enable;
   logic [15:0] imp_sel;
   logic [4:0] readback_count;
   int mismatches, tests_run;
   cgr_config_regs #(.REVISION(REV), .VENDOR(VEN), .DEVICE_TYPE(DTYPE), .DEVICE_ID(DID),
      .DIVIDER_RESET(DIV_RST), .IMP_RESET(IMP_RESET_85)) u_cgr_config_regs (.clock(clock),
      .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
      .blk_start(blk_start), .blk_index(blk_index), .blk_next(blk_next),
      .blk_stop(blk_stop), .blk_valid(blk_valid), .blk_data(blk_data),
      .output_enable_bits(output_enable_bits), .oe_pin_n(oe_pin_n), .ref_enable(ref_enable),
      .power_down_n(power_down_n), .differential_clock_output_true(pair_t),
      .differential_clock_output_comp(pair_c), .differential_clock_output_oe(pair_oe),
      .ref_level(ref_level), .ref_oe(ref_oe), .divider_prog_enable(divider_prog_enable),
      .output_impedance_select(imp_sel), .enable_pin_resistor_select(res_sel),
      .readback_count(readback_count));
   cgr_host_model u_cgr_host_model (.clock(clock), .reg_wr_en(reg_wr_en),
      .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr),
      .reg_rd_data(reg_rd_data), .blk_start(blk_start), .blk_index(blk_index),
      .blk_next(blk_next), .blk_stop(blk_stop));
   // ************************************************************
   // Checking helpers
   // ************************************************************
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_cgr_host_model.rd(a, d);
      chk($sformatf("byte %h", a), {8'h0, d}, {8'h0, e});
   endtask : rc
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      rc(ADDR_RESERVED_C, 8'h00);
      rc(ADDR_RESERVED_A, 8'h00);
      rc(ADDR_RESERVED_B, 8'h00);
      rc(ADDR_REV_VENDOR, {REV, VEN});
      rc(ADDR_DEVICE, {DTYPE, DID});
      rc(ADDR_COUNT, {3'h0, COUNT_RESET});
      rc(ADDR_DIVIDER, {DIV_RST, KEEP_RESET, 6'h0});
      rc(ADDR_STOP, {6'h0, STOP_RESET});
      rc(ADDR_IMP_LOW, IMP_RESET_85[7:0]);
      rc(ADDR_IMP_HIGH, IMP_RESET_85[15:8]);
      rc(ADDR_RESISTOR, 8'h55);
   endtask : t_reset
   task automatic t_block();
      logic [7:0] exp [4];
      exp = '{8'h03, IMP_RESET_85[7:0], IMP_RESET_85[15:8], RESISTOR_RESET};
      u_cgr_host_model.wr(ADDR_COUNT, 8'h03);
      u_cgr_host_model.blk_open(ADDR_IMP_LOW);
      for (int i = 0; i < 4; i++)
      begin
         chk("blk data", {7'h0, blk_valid, blk_data}, {8'h1, exp[i]});
         u_cgr_host_model.blk_ack(1'b0);
      end
      chk("blk end", {15'h0, blk_valid}, 16'h0);
      u_cgr_host_model.blk_open(ADDR_REV_VENDOR);
      u_cgr_host_model.blk_ack(1'b1);
      chk("blk abort", {15'h0, blk_valid}, 16'h0);
   endtask : t_block
   task automatic t_write();
      u_cgr_host_model.wr(ADDR_REV_VENDOR, 8'h00);
      u_cgr_host_model.wr(ADDR_DEVICE, 8'h00);
      u_cgr_host_model.wr(ADDR_RESERVED_B, 8'hff);
      u_cgr_host_model.wr(8'h40, 8'hff);
      rc(ADDR_REV_VENDOR, {REV, VEN});
      rc(ADDR_DEVICE, {DTYPE, DID});
      rc(ADDR_RESERVED_B, 8'h00);
      rc(8'h40, 8'h00);
      u_cgr_host_model.wr(ADDR_COUNT, 8'hff);
      rc(ADDR_COUNT, 8'h1f);
      chk("count", {11'h0, readback_count}, 16'h1f);
      u_cgr_host_model.wr(ADDR_DIVIDER, 8'hbf);
      rc(ADDR_DIVIDER, 8'h80);
      chk("divider", {15'h0, divider_prog_enable}, 16'h1);
      u_cgr_host_model.wr(ADDR_IMP_HIGH, 8'he4);
      rc(ADDR_IMP_HIGH, 8'he4);
      chk("impedance", imp_sel, {8'he4, IMP_RESET_85[7:0]});
      u_cgr_host_model.wr(ADDR_RESISTOR, 8'hc6);
      chk("resistor", {8'h0, res_sel}, 16'hc6);
   endtask : t_write
   task automatic t_stop();
      logic [1:0] c;
      logic [3:0] t, cp, o;
      output_enable_bits = 8'h0f;
      ref_enable = 1'b0;
      for (int s = 0; s < 4; s++)
      begin
         c = 2'(s);
         u_cgr_host_model.wr(ADDR_STOP, {6'h3f, c});
         repeat (2) @(negedge clock);
         o = (c == STOP_HIZ) ? 4'h0 : 4'hf;
         t = (c == STOP_HIGH_LOW) ? 4'hf : 4'h0;
         cp = (c == STOP_LOW_HIGH) ? 4'hf : 4'h0;
         chk("pair oe", {8'h0, pair_oe}, {8'h0, o, 4'hf});
         chk("ref oe", {15'h0, ref_oe}, {15'h0, c != STOP_HIZ});
         if (c != STOP_HIZ)
         begin
            chk("pair lvl", {pair_t, pair_c}, {t, 4'hf, cp, 4'h0});
            chk("ref lvl", {15'h0, ref_level}, {15'h0, c == STOP_LOW_HIGH});
         end
      end
      rc(ADDR_STOP, {6'h0, STOP_LOW_HIGH});
      // A high pin stops pair 0 even with its bit set
      oe_pin_n = 8'h01;
      repeat (4) @(negedge clock);
      chk("pin stop", {14'h0, pair_t[0], pair_c[0]}, 16'h1);
      oe_pin_n = 8'h00;
      output_enable_bits = 8'hff;
      ref_enable = 1'b1;
   endtask : t_stop
   task automatic t_powerdown();
      u_cgr_host_model.wr(ADDR_DIVIDER, 8'h00);
      u_cgr_host_model.wr(ADDR_IMP_LOW, 8'h1b);
      power_down_n = 1'b0;
      repeat (5) @(negedge clock);
      power_down_n = 1'b1;
      repeat (3) @(negedge clock);
      rc(ADDR_IMP_LOW, IMP_RESET_85[7:0]);
      rc(ADDR_DIVIDER, {DIV_RST, KEEP_RESET, 6'h0});
      chk("count pd", {11'h0, readback_count}, {11'h0, COUNT_RESET});
   endtask : t_powerdown
   // ************************************************************
   // Clock, reset, sequence and watchdog
   // ************************************************************
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial
   begin
      {mismatches, tests_run} = '0;
      {sys_rst, ref_enable, power_down_n} = 3'h7;
      output_enable_bits = 8'hff;
      oe_pin_n = 8'h00;
      repeat (6) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      t_reset();
      t_block();
      t_write();
      t_stop();
      t_powerdown();
      finish_test();
   end
   initial
   begin
      // Whole sequence needs about 110 cycles
      repeat (5000) @(posedge clock);
      mismatches++;
      finish_test();
   end
endmodule : tb_top
